// >>> dfp_pkg.sv
// Package for the DAC fault, configuration and power-down block.
// Assumes a 200 MHz system clock and a 32-bit serial word frame.
package dfp_pkg;

	// -------------------------------------------------------------------
	// Sizes and serial word fields
	// -------------------------------------------------------------------
	localparam int NUM_CH = 5;
	localparam int WORD_W = 32;
	localparam int CNT_W  = 5;
	localparam int CMD_MSB  = 23;
	localparam int CMD_LSB  = 20;
	localparam int ADDR_MSB = 19;
	localparam int ADDR_LSB = 16;
	localparam int LOW_W    = 24;  // Command, address and data of a word.
	localparam logic [CNT_W-1:0] LEN_SHORT = 5'h18;  // 24-bit words.
	localparam logic [CNT_W-1:0] LEN_WRAP  = 5'h1F;  // Last count before 32.

	// -------------------------------------------------------------------
	// Command codes
	// -------------------------------------------------------------------
	localparam logic [3:0] CMD_UPD_N      = 4'h1;
	localparam logic [3:0] CMD_WR_UPD_N   = 4'h3;
	localparam logic [3:0] CMD_PD_CHAN    = 4'h4;
	localparam logic [3:0] CMD_PD_CHIP    = 4'h5;
	localparam logic [3:0] CMD_SPAN_N     = 4'h6;
	localparam logic [3:0] CMD_CONFIG     = 4'h7;
	localparam logic [3:0] CMD_UPD_ALL    = 4'h9;
	localparam logic [3:0] CMD_WR_UPD_ALL = 4'hA;
	localparam logic [3:0] CMD_SPAN_ALL   = 4'hE;

	// -------------------------------------------------------------------
	// Span codes and configuration bit positions in the data field
	// -------------------------------------------------------------------
	localparam logic [3:0] SPAN_HIZ    = 4'h0;
	localparam logic [3:0] SPAN_100MA  = 4'h4;
	localparam logic [3:0] SPAN_200MA  = 4'h5;
	localparam logic [3:0] SPAN_300MA  = 4'h6;
	localparam logic [3:0] SPAN_SWITCH = 4'h8;
	localparam int CFG_OC_BIT = 3;
	localparam int CFG_PL_BIT = 2;
	localparam int CFG_TS_BIT = 1;
	localparam int CFG_RD_BIT = 0;

	// -------------------------------------------------------------------
	// Reset values and power-up timing
	// -------------------------------------------------------------------
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [3:0] SPAN_RST  = SPAN_HIZ;
	localparam int CLK_MHZ    = 200;
	localparam int PU_CHAN_US = 30;
	localparam int PU_CHIP_US = 35;
	localparam int PU_CHAN_CYCLES = PU_CHAN_US * CLK_MHZ;
	localparam int PU_CHIP_CYCLES = PU_CHIP_US * CLK_MHZ;
	localparam int PU_W = 13;

	// -------------------------------------------------------------------
	// Types
	// -------------------------------------------------------------------
	typedef struct packed {
		logic openDetectDisable;
		logic powerLimitDisable;
		logic thermalProtectDisable;
		logic extRefSel;
	} dfp_cfg_t;

	typedef struct packed {
		logic              badLengthFlag;
		logic              powerLimitFlag;
		logic              overtempFlag;
		logic [NUM_CH-1:0] openCircuitFlags;
	} dfp_flags_t;

	typedef struct packed {
		logic [WORD_W-1:0] word;
		logic [CNT_W-1:0]  bitCnt;
		logic              wrapped;
		logic              frameTog;
	} dfp_frame_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FRAME = 2'b01,
		ST_EXEC  = 2'b11
	} dfp_state_t;

endpackage

// >>> dfp_sync.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; multi-bit words must not pass here.
`timescale 1ns/10ps
module dfp_sync #(
	parameter int              W    = 1,
	parameter logic [W-1:0]    INIT = '0
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// -------------------------------------------------------------------
	// Synchroniser stages
	// -------------------------------------------------------------------
	// Only the second stage reads the first one.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta <= INIT;
			q    <= INIT;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// >>> dfp_link_shift.sv
// Serial shift logic on the serial clock, framed by chip select.
// Assumes the serial clock stands still while chip select is high.
`timescale 1ns/10ps
module dfp_link_shift
	import dfp_pkg::*;
(
	input  wire logic              sck,
	input  wire logic              rst_n,
	input  wire logic              csLdN,
	input  wire logic              sdi,
	input  wire logic [WORD_W-1:0] echoWord,
	output logic                   sdo,
	output dfp_frame_t             frame
);
	logic       started;
	dfp_frame_t next_frame;
	logic       next_sdo;

	// -------------------------------------------------------------------
	// Frame start marker
	// -------------------------------------------------------------------
	// Cleared by the frame's own select, since no clock edge follows it.
	always_ff @(posedge sck or posedge csLdN) begin
		if (csLdN) begin
			started <= 1'b0;
		end else begin
			started <= 1'b1;
		end
	end

	// The first edge loads the echo word; later edges shift sdi through.
	always_comb begin
		next_frame = frame;
		next_sdo   = started ? frame.word[WORD_W-1] : echoWord[WORD_W-1];
		if (!started) begin
			next_frame.word     = {echoWord[WORD_W-2:0], sdi};
			next_frame.bitCnt   = 5'h01;
			next_frame.wrapped  = 1'b0;
			next_frame.frameTog = ~frame.frameTog;
		end else begin
			next_frame.word    = {frame.word[WORD_W-2:0], sdi};
			next_frame.bitCnt  = frame.bitCnt + 5'h01;
			next_frame.wrapped = frame.wrapped
				| (frame.bitCnt == LEN_WRAP);
		end
	end

	// The word is held after the frame so the system side can read it.
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			frame <= '0;
			sdo   <= 1'b0;
		end else begin
			frame <= next_frame;
			sdo   <= next_sdo;
		end
	end
endmodule

// >>> dfp_fault_power.sv
// Fault flags, alert, configuration and power-down control of a
// five-channel current DAC with a three-wire serial port.
// Assumes analog detectors arrive as asynchronous levels on pins.
//
// Functional notes
// - Alert pulls low on any fault; released at next select rising edge.
// - Each of five outputs has its own open-circuit flag on dropout.
// - Overtemperature sets its flag, powers down all channels, pulls alert.
// - Overtemperature flag and shutdown hold until the die has cooled.
// - Select rising edge releases alert even while still overheated.
// - Power-limit flag rises for 200mA or 300mA spans at 10V headroom.
// - A power-limit trip reduces that channel to the 100mA span.
// - Lengths other than 24 or multiples of 32 flag, alert, discard.
// - Configuration has four bits; open-detect disable stops open flags.
// - Disable bits turn off power-limit and thermal protection and flags.
// - Reference select bit chooses external reference when set.
// - Configuration command code is 0111b.
// - Code 0100b powers down the addressed channel, output high impedance.
// - Code 0101b powers down all channels and the reference.
// - Power-down commands ignore the data field.
// - Register contents survive any power-down.
// - Any update, by command or toggle, powers a channel back up, except during thermal shutdown.
// - Power-up takes 30us after channel, 35us after chip power-down.
// - Span 1000b turns off current and closes the negative switch.
// - The negative switch span comes only through span write commands.
// - Flags are caught on detection and echoed in the next transaction.
// - The flag byte leads every echoed word.
`timescale 1ns/10ps
module dfp_fault_power
	import dfp_pkg::*;
#(
	parameter int PU_CHAN_CYC = PU_CHAN_CYCLES,
	parameter int PU_CHIP_CYC = PU_CHIP_CYCLES
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              sck,
	input  wire logic              csLdN,
	input  wire logic              sdi,
	output logic                   sdo,
	output logic                   sdoOe,
	input  wire logic [NUM_CH-1:0] dropoutDet,
	input  wire logic              overTempDet,
	input  wire logic              coolDet,
	input  wire logic [NUM_CH-1:0] powerLimitDet,
	input  wire logic [NUM_CH-1:0] toggleUpdate,
	output logic                   faultOe,
	output logic [NUM_CH-1:0]      chanPowerDown,
	output logic                   refPowerDown,
	output logic [NUM_CH-1:0]      chanReady,
	output logic [NUM_CH-1:0]      updateStrobe,
	output logic [NUM_CH-1:0]      switchToNeg,
	output logic [NUM_CH*4-1:0]    spanCodes,
	output dfp_cfg_t               cfg,
	output dfp_flags_t             statusFlagByte,
	output logic                   thermalShutdown
);

	// -------------------------------------------------------------------
	// Elaboration checks
	// -------------------------------------------------------------------
	if (PU_CHAN_CYC < 1 || PU_CHAN_CYC >= (1 << PU_W) ||
	    PU_CHIP_CYC < 1 || PU_CHIP_CYC >= (1 << PU_W)) begin : g_chk
		$error("Power-up counts do not fit the counter.");
	end

	localparam logic [PU_W-1:0] PU_CHAN_LD = PU_W'(PU_CHAN_CYC);
	localparam logic [PU_W-1:0] PU_CHIP_LD = PU_W'(PU_CHIP_CYC);

	// Address decode, used by power-down, span and update commands.
	function automatic logic [NUM_CH-1:0] chanMask(input logic [3:0] addr);
		logic [NUM_CH-1:0] m;
		m = '0;
		if (addr < 4'(NUM_CH)) begin
			m[addr[2:0]] = 1'b1;
		end
		return m;
	endfunction

	// -------------------------------------------------------------------
	// Link side and crossings
	// -------------------------------------------------------------------
	dfp_frame_t        frame;
	logic [WORD_W-1:0] echoWord;
	logic              csS;
	logic              togS;
	logic [NUM_CH-1:0] dropS;
	logic [NUM_CH-1:0] plS;
	logic              otS;
	logic              coolS;

	dfp_link_shift u_link (
		.sck      (sck),
		.rst_n    (rst_n),
		.csLdN    (csLdN),
		.sdi      (sdi),
		.echoWord (echoWord),
		.sdo      (sdo),
		.frame    (frame)
	);

	// Select, the detector pins and the frame toggle are levels; each passes two flops.
	dfp_sync #(.W(2 * NUM_CH + 4), .INIT({1'b1, {(2 * NUM_CH + 3){1'b0}}}))
	u_sync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.d     ({csLdN, frame.frameTog, dropoutDet, powerLimitDet,
		         overTempDet, coolDet}),
		.q     ({csS, togS, dropS, plS, otS, coolS})
	);

	// -------------------------------------------------------------------
	// Frame sequencing
	// -------------------------------------------------------------------
	dfp_state_t        state;
	dfp_state_t        next_state;
	logic              lastTog;
	logic              next_lastTog;
	logic [LOW_W-1:0]  prevLow;
	logic [LOW_W-1:0]  next_prevLow;
	logic [WORD_W-1:0] next_echoWord;
	logic              next_sdoOe;
	logic              exec;
	logic              frameSeen;
	logic              lenValid;
	logic              accept;
	logic [3:0]        cmd;
	logic [NUM_CH-1:0] addrMask;

	assign exec      = (state == ST_EXEC);
	assign frameSeen = (togS != lastTog);
	assign cmd       = frame.word[CMD_MSB:CMD_LSB];
	assign addrMask  = chanMask(frame.word[ADDR_MSB:ADDR_LSB]);
	// A count of 24 with no wrap, or a whole number of 32-bit words.
	assign lenValid  = (!frame.wrapped && frame.bitCnt == LEN_SHORT)
		|| (frame.wrapped && frame.bitCnt == '0);
	assign accept    = exec && frameSeen && lenValid;

	// The word is read only in the exec cycle, while select is high and
	// the serial clock stands, so it is stable across the crossing.
	always_comb begin
		next_state    = state;
		next_lastTog  = lastTog;
		next_prevLow  = prevLow;
		next_echoWord = echoWord;
		next_sdoOe    = !csS;
		unique case (state)
			ST_IDLE: begin
				// Echo is frozen once select falls.
				next_echoWord = {statusFlagByte, prevLow};
				if (!csS) begin
					next_state = ST_FRAME;
				end
			end
			ST_FRAME: begin
				if (csS) begin
					next_state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				next_state   = ST_IDLE;
				next_lastTog = togS;
				if (frameSeen) begin
					next_prevLow = frame.word[LOW_W-1:0];
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state    <= ST_IDLE;
			lastTog  <= 1'b0;
			prevLow  <= '0;
			echoWord <= '0;
			sdoOe    <= 1'b0;
		end else begin
			state    <= next_state;
			lastTog  <= next_lastTog;
			prevLow  <= next_prevLow;
			echoWord <= next_echoWord;
			sdoOe    <= next_sdoOe;
		end
	end

	// -------------------------------------------------------------------
	// Configuration, spans and thermal shutdown
	// -------------------------------------------------------------------
	dfp_cfg_t          next_cfg;
	logic [3:0]        span [NUM_CH];
	logic [3:0]        next_span [NUM_CH];
	logic [NUM_CH-1:0] plHit;
	logic              next_shutdown;

	// Disable bits and the reference select come from a config word.
	always_comb begin
		next_cfg = cfg;
		if (accept && cmd == CMD_CONFIG) begin
			next_cfg.openDetectDisable     = frame.word[CFG_OC_BIT];
			next_cfg.powerLimitDisable     = frame.word[CFG_PL_BIT];
			next_cfg.thermalProtectDisable = frame.word[CFG_TS_BIT];
			next_cfg.extRefSel             = frame.word[CFG_RD_BIT];
		end
	end

	// Shutdown holds until the cool detector reports, unless disabled.
	always_comb begin
		if (cfg.thermalProtectDisable) begin
			next_shutdown = 1'b0;
		end else if (otS) begin
			next_shutdown = 1'b1;
		end else if (coolS) begin
			next_shutdown = 1'b0;
		end else begin
			next_shutdown = thermalShutdown;
		end
	end

	// Protection overrides a span written in the same cycle.
	for (genvar i = 0; i < NUM_CH; i++) begin : g_span
		assign plHit[i] = plS[i] && !cfg.powerLimitDisable
			&& (span[i] == SPAN_200MA || span[i] == SPAN_300MA);
		always_comb begin
			next_span[i] = span[i];
			if (accept && ((cmd == CMD_SPAN_N && addrMask[i])
			    || cmd == CMD_SPAN_ALL)) begin
				next_span[i] = frame.word[3:0];
			end
			if (plHit[i]) begin
				next_span[i] = SPAN_100MA;
			end
		end
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				span[i]        <= SPAN_RST;
				switchToNeg[i] <= 1'b0;
			end else begin
				span[i]        <= next_span[i];
				switchToNeg[i] <= (next_span[i] == SPAN_SWITCH);
			end
		end
		assign spanCodes[i*4 +: 4] = span[i];
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cfg             <= '0;
			thermalShutdown <= 1'b0;
		end else begin
			cfg             <= next_cfg;
			thermalShutdown <= next_shutdown;
		end
	end

	// -------------------------------------------------------------------
	// Power-down and power-up timing
	// -------------------------------------------------------------------
	logic [NUM_CH-1:0] updMask;
	logic [NUM_CH-1:0] next_chanPd;
	logic              next_refPd;
	logic [PU_W-1:0]   puCnt [NUM_CH];
	logic [PU_W-1:0]   next_puCnt [NUM_CH];

	// Updates are held off while the die is too hot.
	always_comb begin
		updMask = toggleUpdate;
		if (accept && (cmd == CMD_UPD_N || cmd == CMD_WR_UPD_N)) begin
			updMask = updMask | addrMask;
		end
		if (accept && (cmd == CMD_UPD_ALL || cmd == CMD_WR_UPD_ALL)) begin
			updMask = '1;
		end
		if (thermalShutdown) begin
			updMask = '0;
		end
	end

	// Spans, config and codes are never touched here.
	always_comb begin
		next_chanPd = chanPowerDown;
		next_refPd  = refPowerDown;
		if (accept && cmd == CMD_PD_CHAN) begin
			next_chanPd = next_chanPd | addrMask;
		end
		if (accept && cmd == CMD_PD_CHIP) begin
			next_chanPd = '1;
			next_refPd  = 1'b1;
		end
		if (|updMask) begin
			next_chanPd = next_chanPd & ~updMask;
			next_refPd  = 1'b0;
		end
		if (thermalShutdown) begin
			next_chanPd = '1;
		end
	end

	// A waking channel waits the longer time if the chip was down.
	for (genvar i = 0; i < NUM_CH; i++) begin : g_pu
		always_comb begin
			next_puCnt[i] = puCnt[i];
			if (updMask[i] && chanPowerDown[i]) begin
				next_puCnt[i] = refPowerDown ? PU_CHIP_LD : PU_CHAN_LD;
			end else if (puCnt[i] != '0) begin
				next_puCnt[i] = puCnt[i] - 1'b1;
			end
		end
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				puCnt[i] <= '0;
			end else begin
				puCnt[i] <= next_puCnt[i];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			chanPowerDown <= '0;
			refPowerDown  <= 1'b0;
			updateStrobe  <= '0;
			chanReady     <= '0;
		end else begin
			chanPowerDown <= next_chanPd;
			refPowerDown  <= next_refPd;
			updateStrobe  <= updMask;
			for (int i = 0; i < NUM_CH; i++) begin
				chanReady[i] <= !next_chanPd[i] && next_puCnt[i] == '0;
			end
		end
	end

	// -------------------------------------------------------------------
	// Fault flags and alert
	// -------------------------------------------------------------------
	dfp_flags_t flagSet;
	dfp_flags_t flagClr;
	dfp_flags_t next_flags;
	logic       next_fault;

	// Disabled detectors neither set flags nor reach the alert.
	always_comb begin
		flagSet.openCircuitFlags = dropS
			& {NUM_CH{!cfg.openDetectDisable}};
		flagSet.overtempFlag   = thermalShutdown;
		flagSet.powerLimitFlag = |plHit;
		flagSet.badLengthFlag  = exec && frameSeen && !lenValid;
		// Only the flags already echoed are cleared; set wins.
		flagClr    = exec ? dfp_flags_t'(echoWord[WORD_W-1:LOW_W]) : '0;
		next_flags = (statusFlagByte & ~flagClr) | flagSet;
	end

	// A fresh flag pulls the alert; a select rising edge releases it.
	always_comb begin
		if (|(flagSet & ~statusFlagByte)) begin
			next_fault = 1'b1;
		end else if (exec) begin
			next_fault = 1'b0;
		end else begin
			next_fault = faultOe;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			statusFlagByte <= FLAGS_RST;
			faultOe        <= 1'b0;
		end else begin
			statusFlagByte <= next_flags;
			faultOe        <= next_fault;
		end
	end

endmodule

// >>> dfp_fault_power_sva.sv
// Checker for the fault and power-down block, seen at its ports.
// Assumes small power-up counts handed down by the bind below.
`timescale 1ns/10ps
module dfp_fault_power_sva
	import dfp_pkg::*;
#(
	parameter int PU_CHAN_CYC = 20,
	parameter int PU_CHIP_CYC = 30
) (
	input wire logic                mclk,
	input wire logic                rst_n,
	input wire logic                csLdN,
	input wire logic [NUM_CH-1:0]   dropoutDet,
	input wire logic                overTempDet,
	input wire logic                coolDet,
	input wire logic [NUM_CH-1:0]   powerLimitDet,
	input wire logic                faultOe,
	input wire logic [NUM_CH-1:0]   chanPowerDown,
	input wire logic [NUM_CH-1:0]   chanReady,
	input wire logic [NUM_CH-1:0]   updateStrobe,
	input wire logic [NUM_CH-1:0]   switchToNeg,
	input wire logic [NUM_CH*4-1:0] spanCodes,
	input wire dfp_cfg_t            cfg,
	input wire dfp_flags_t          statusFlagByte,
	input wire logic                thermalShutdown
);
	// Longest wait for ready, with slack for the command latency.
	localparam int RDY_MAX = PU_CHIP_CYC + 8;
	logic [NUM_CH-1:0] swExp;

	// Expected switch state of every channel from its span code.
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			swExp[i] = spanCodes[4*i+:4] == SPAN_SWITCH;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// A frame ends while neither the dropout nor the power-limit detectors could re-arm the alert.
	sequence frameEnd;
		$rose(csLdN) && !(|dropoutDet) && !(|powerLimitDet);
	endsequence
	// A woken channel waits a while, then reports ready.
	sequence wakeWait;
		!chanReady[0] [*8] ##[1:RDY_MAX] chanReady[0];
	endsequence

	alert_release_a: assert property (
		frameEnd |-> ##[1:8] (!faultOe || statusFlagByte.badLengthFlag))
		else $error("alert not released after frame");
	alert_cause_a: assert property (
		$rose(faultOe) |-> statusFlagByte != FLAGS_RST)
		else $error("alert without a flag");
	overtemp_down_a: assert property (
		overTempDet && !cfg.thermalProtectDisable |-> ##[1:6]
		(thermalShutdown && &chanPowerDown && statusFlagByte.overtempFlag))
		else $error("overtemperature not acted on");
	hot_hold_a: assert property (
		(!coolDet) [*4] ##0 (thermalShutdown && !cfg.thermalProtectDisable)
		|=> thermalShutdown)
		else $error("shutdown left before cooling");
	power_limit_a: assert property (
		(spanCodes[7:4] == SPAN_200MA || spanCodes[7:4] == SPAN_300MA)
		&& powerLimitDet[1] && !cfg.powerLimitDisable |-> ##[1:6]
		(spanCodes[7:4] == SPAN_100MA && statusFlagByte.powerLimitFlag))
		else $error("power limit not acted on");
	limit_off_a: assert property (
		cfg.powerLimitDisable && $past(cfg.powerLimitDisable)
		|-> !$rose(statusFlagByte.powerLimitFlag))
		else $error("power limit flag while disabled");
	open_flag_a: assert property (
		dropoutDet[3] && !cfg.openDetectDisable
		|-> ##[1:5] statusFlagByte.openCircuitFlags[3])
		else $error("open circuit flag missing");
	open_off_a: assert property (
		cfg.openDetectDisable && $past(cfg.openDetectDisable) |->
		(statusFlagByte.openCircuitFlags &
		~$past(statusFlagByte.openCircuitFlags)) == '0)
		else $error("open circuit flag while disabled");
	switch_span_a: assert property (
		$stable(spanCodes) |-> switchToNeg == swExp)
		else $error("switch state disagrees with span");
	wake_update_a: assert property (
		updateStrobe[0] && !thermalShutdown |-> ##[0:1] !chanPowerDown[0])
		else $error("update left channel down");
	ready_wait_a: assert property (
		$fell(chanPowerDown[0]) |-> wakeWait)
		else $error("ready timing wrong");
endmodule

bind dfp_fault_power dfp_fault_power_sva #(
	.PU_CHAN_CYC(PU_CHAN_CYC),
	.PU_CHIP_CYC(PU_CHIP_CYC)
) chk (
	.mclk(mclk), .rst_n(rst_n), .csLdN(csLdN), .dropoutDet(dropoutDet),
	.overTempDet(overTempDet), .coolDet(coolDet),
	.powerLimitDet(powerLimitDet), .faultOe(faultOe),
	.chanPowerDown(chanPowerDown), .chanReady(chanReady),
	.updateStrobe(updateStrobe), .switchToNeg(switchToNeg),
	.spanCodes(spanCodes), .cfg(cfg), .statusFlagByte(statusFlagByte),
	.thermalShutdown(thermalShutdown)
);

// >>> dfp_host_model.sv
// Serial host model that frames words on the three-wire port.
// Assumes the bench calls xfer and idles the link in between.
`timescale 1ns/10ps
module dfp_host_model (
	output logic      sck,
	output logic      csLdN,
	output logic      sdi,
	input wire logic  sdo
);
	logic [31:0] echo;

	// Clock stands still and select is high outside frames.
	initial begin
		sck = 1'h0;
		csLdN = 1'h0;
		sdi = 1'h0;
		#1 csLdN = 1'h1;  // A real rising edge clears the frame marker.
	end

	// One frame, MSB first; lag stretches each low phase for a slow host.
	task automatic xfer(input logic [63:0] w, input int n, input int lag);
		#7 csLdN = 1'h0;
		#20;
		for (int i = n - 1; i >= 0; i--) begin
			sdi = w[i];
			#(15 + lag);
			sck = 1'h1;
			#15;
			sck = 1'h0;
			echo = {echo[30:0], sdo};
		end
		#15 csLdN = 1'h1;
		sdi = ~sdi;  // Released line shows no stale value.
	endtask
endmodule

// >>> dfp_fault_power_tb.sv
// Self-checking bench for the fault and power-down block.
// Assumes the host model and the bound checker are compiled too.
`timescale 1ns/10ps
module dfp_fault_power_tb
	import dfp_pkg::*;
;
	// Short power-up waits keep the run brief.
	localparam int PU_CH = 20;
	localparam int PU_CP = 30;
	logic              mclk, rst_n, sck, csLdN, sdi, sdo, sdoOe, coolDet;
	logic              overTempDet, faultOe, refPowerDown, thermalShutdown;
	logic [NUM_CH-1:0] dropoutDet, powerLimitDet, toggleUpdate, chanReady;
	logic [NUM_CH-1:0] chanPowerDown, updateStrobe, switchToNeg;
	logic [19:0]       spanCodes;
	dfp_cfg_t          cfg;
	dfp_flags_t        statusFlagByte;
	int                fail_count = 0;
	int                samples_checked = 0;
	int                cyc;
	logic [3:0]        upd [4];

	dfp_fault_power #(.PU_CHAN_CYC(PU_CH), .PU_CHIP_CYC(PU_CP)) uut (
		.mclk(mclk), .rst_n(rst_n), .sck(sck), .csLdN(csLdN), .sdi(sdi),
		.sdo(sdo), .sdoOe(sdoOe), .dropoutDet(dropoutDet),
		.overTempDet(overTempDet), .coolDet(coolDet),
		.powerLimitDet(powerLimitDet), .toggleUpdate(toggleUpdate),
		.faultOe(faultOe), .chanPowerDown(chanPowerDown),
		.refPowerDown(refPowerDown), .chanReady(chanReady),
		.updateStrobe(updateStrobe), .switchToNeg(switchToNeg),
		.spanCodes(spanCodes), .cfg(cfg), .statusFlagByte(statusFlagByte),
		.thermalShutdown(thermalShutdown)
	);
	// The data-out line has a pull-up, so released it reads high.
	dfp_host_model host (
		.sck(sck), .csLdN(csLdN), .sdi(sdi), .sdo(sdoOe ? sdo : 1'h1)
	);

	// System clock at 200 MHz.
	initial begin
		mclk = 1'h0;
		forever #2.5 mclk = ~mclk;
	end

	// -------------------------------------------------------------
	// Tasks
	// -------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One word, then enough cycles for its effects to land.
	task automatic frame(input logic [3:0] c, input logic [3:0] a,
		input logic [15:0] d, input int n = 32, input int lag = 0);
		host.xfer({32'hA5A5A5A5, 8'h00, c, a, d}, n, lag);
		tick(8);
	endtask

	// Bounded wait for a channel to report ready.
	task automatic waitReady(input int ch, output int c);
		c = 0;
		while (chanReady[ch] !== 1'h1 && c < 100) begin
			tick(1);
			c++;
		end
		if (c >= 100) begin
			fail_count++;
			stop_test();
		end
	endtask

	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial begin
		upd = '{CMD_UPD_N, CMD_WR_UPD_N, CMD_UPD_ALL, CMD_WR_UPD_ALL};
		// Reset falls after time zero so the link flops see the edge.
		{rst_n, coolDet, overTempDet} = 3'h4;
		#1 rst_n = 1'h0;
		{dropoutDet, powerLimitDet, toggleUpdate} = 15'h0000;
		tick(5);
		rst_n = 1'h1;
		tick(3);
		check("reset", {cfg, statusFlagByte, spanCodes}, 32'h0);
		for (int b = 0; b < 4; b++) begin
			frame(CMD_CONFIG, 4'h0, 16'h1 << b, 32, 10 * b);
			check("cfg bit", cfg, 4'h1 << b);
		end
		frame(CMD_SPAN_N, 4'h2, {12'h000, SPAN_SWITCH});
		check("switch", switchToNeg, 5'h04);
		frame(CMD_SPAN_ALL, 4'h0, {12'h000, SPAN_200MA});
		check("span all", {switchToNeg, spanCodes}, 25'h0055555);
		$display("config and span tests done");
		powerLimitDet = 5'h02;
		tick(8);
		check("pl trip", {faultOe, spanCodes}, 21'h155545);
		powerLimitDet = 5'h00;
		frame(CMD_SPAN_N, 4'h1, {12'h000, SPAN_300MA});
		check("echo", host.echo, {8'h40, CMD_SPAN_ALL, 20'h00005});
		check("pl release", faultOe, 1'h0);
		frame(CMD_CONFIG, 4'h0, 16'h0004);
		powerLimitDet = 5'h02;
		tick(8);
		check("pl off", {statusFlagByte, spanCodes}, 28'h0055565);
		powerLimitDet = 5'h00;
		frame(CMD_CONFIG, 4'h0, 16'h0000);
		dropoutDet = 5'h08;
		tick(8);
		check("open", {faultOe, statusFlagByte}, 9'h108);
		dropoutDet = 5'h00;
		frame(CMD_CONFIG, 4'h0, 16'h0008);
		check("open echo", host.echo[31:24], 8'h08);
		dropoutDet = 5'h01;
		tick(8);
		check("open off", {faultOe, statusFlagByte}, 9'h000);
		dropoutDet = 5'h00;
		$display("fault flag tests done");
		frame(CMD_CONFIG, 4'h0, 16'h0002, 31);
		check("bad len", {faultOe, statusFlagByte, cfg}, 13'h1808);
		frame(CMD_CONFIG, 4'h0, 16'h0002, 24);
		check("len 24", {faultOe, statusFlagByte, cfg}, 13'h0002);
		frame(CMD_CONFIG, 4'h0, 16'h0000, 64);
		check("len 64", cfg, 4'h0);
		$display("length tests done");
		frame(CMD_PD_CHAN, 4'h0, 16'hFFFF);
		check("pd chan", {chanPowerDown, spanCodes}, 25'h0155565);
		frame(CMD_UPD_N, 4'h0, 16'h0000);
		check("wake", {chanPowerDown, chanReady[0]}, 6'h00);
		waitReady(0, cyc);
		check("chan wait", cyc > PU_CH - 12 && cyc <= PU_CH, 1'h1);
		frame(CMD_PD_CHIP, 4'h3, 16'h1234);
		check("pd chip", {chanPowerDown, refPowerDown}, 6'h3F);
		toggleUpdate = 5'h04;
		tick(1);
		toggleUpdate = 5'h00;
		check("strobe", updateStrobe, 5'h04);
		waitReady(2, cyc);
		check("chip wait", cyc > PU_CP - 6 && cyc <= PU_CP, 1'h1);
		check("toggle", {chanPowerDown, spanCodes}, 25'h1B55565);
		foreach (upd[k]) begin
			frame(CMD_PD_CHAN, 4'h1, 16'h0000);
			frame(upd[k], 4'h1, 16'h8000);
			check("wake code", chanPowerDown[1], 1'h0);
		end
		$display("power-down tests done");
		overTempDet = 1'h1;
		tick(8);
		check("hot", {thermalShutdown, chanPowerDown, faultOe}, 7'h7F);
		frame(CMD_UPD_ALL, 4'h0, 16'h0000);
		check("hot rel", {faultOe, thermalShutdown}, 2'h1);
		overTempDet = 1'h0;
		tick(8);
		check("cooling", {thermalShutdown, chanPowerDown}, 6'h3F);
		coolDet = 1'h1;
		tick(8);
		frame(CMD_UPD_ALL, 4'h0, 16'h0000);
		check("resume", {thermalShutdown, chanPowerDown}, 6'h00);
		$display("thermal tests done");
		stop_test();
	end
endmodule
